// >>> hw/usps_uart.sv
// usps_uart: serial port registers, baud divider, transmitter and receiver.
// assumes an AXI4-Lite master on the register side and a serial partner on the line side.
// Operation
// R1: receiving only while receive enable is set
// R2: nine-bit modes send transmit ninth bit
// R3: latch ninth bit, or stop bit in mode 1
// R4: transmit done at bit 8 or stop start
// R5: hardware never clears transmit done
// R6: receive done at bit 8 or mid-stop
// R7: eight-bit data buffer resetting to zero
// R8: overwrite error when receive done still set
// R9: frame error read-only, refreshed each frame
// R10: break error on 10.5 bit-time low line; the code sets it in modes 2 and 3 only
// R11: extended ratio field stretches the divider
// R12: binary field divides by two to field
// R13: mode bits select one of four modes
// R14: multiprocessor bit suppresses unwanted receive done
// R15: buffer write starts transmission, LSB first
// R16: writes to frame error bit are ignored
//
// Design decision made here: register access over AXI4-Lite.
`default_nettype none
module usps_uart (
	input  wire logic                          clk_sys_i,
	input  wire logic                          rst_i,
	input  wire logic [usps_pkg::ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [usps_pkg::ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	input  wire logic                          rxd_i,
	output logic                               rxd_o,
	output logic                               rxd_oe_o,
	output logic                               txd_o,
	output logic                               irq_o
);
	typedef enum {TX_IDLE, TX_RUN} usps_tx_t;
	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_M0} usps_rx_t;

	usps_pkg::usps_ctrl_t           ctrl_q, ctrl_d;
	usps_pkg::usps_baud_t           baud_q, baud_d;
	logic [7:0]                     serial_data_buffer_q, serial_data_buffer_d;
	logic [usps_pkg::IRQ_W-1:0]     ist_q, ist_d, imsk_q, imsk_d;
	logic                           pend_q, pend_d;
	logic                           aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [9:0]                     aw_idx_q, aw_idx_d;
	logic [7:0]                     wdat_q, wdat_d;
	logic                           wstb_q, wstb_d;
	logic                           bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0]                     bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0]                    rdata_q, rdata_d;
	logic                           do_wr, do_rd, rd_istat;
	logic [9:0]                     ar_idx;
	logic [15:0]                    bit_cyc, half_cyc;
	logic [19:0]                    brk_lim;
	usps_tx_t                       tx_st_q, tx_st_d;
	logic [10:0]                    tx_sh_q, tx_sh_d;
	logic [3:0]                     tx_left_q, tx_left_d;
	logic [15:0]                    tx_cnt_q, tx_cnt_d;
	logic                           txd_q, txd_d, rxd_out_q, rxd_out_d, rxd_oe_q, rxd_oe_d;
	logic                           tx_done_ev;
	usps_rx_t                       rx_st_q, rx_st_d;
	logic [8:0]                     rx_sh_q, rx_sh_d;
	logic [3:0]                     rx_left_q, rx_left_d;
	logic [15:0]                    rx_cnt_q, rx_cnt_d;
	logic                           rxd_prev_q;
	logic [19:0]                    brk_cnt_q, brk_cnt_d;
	logic                           frame_ev, load_ev, fe_val, be_val;
	logic [7:0]                     rx_byte;
	logic                           rx_bit9;

	// bit period from mode and divider fields
	always_comb begin
		unique case (ctrl_q.mode)  // see R13
			usps_pkg::MODE_SHIFT: bit_cyc = usps_pkg::MODE0_CYC;
			usps_pkg::MODE_9FIX:  bit_cyc = usps_pkg::MODE2_CYC;
			default:              bit_cyc = 16'((usps_pkg::BASE_CYC << baud_q.bin_div)
			                                * (16'(baud_q.ext_ratio) + 16'h0001)); // see R11, R12
		endcase
		half_cyc = bit_cyc >> 1;
		brk_lim  = 20'(20'(half_cyc) * usps_pkg::BRK_HALVES);
	end

	// bus handshakes: write address and data taken in either order
	assign s_axi_awready = !aw_have_q;
	assign s_axi_wready  = !w_have_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;
	assign do_wr    = aw_have_q && w_have_q && !bvalid_q;
	assign do_rd    = s_axi_arvalid && !rvalid_q;
	assign ar_idx   = s_axi_araddr[usps_pkg::ADDR_W-1:2];
	assign rd_istat = do_rd && (ar_idx == usps_pkg::IDX_ISTAT);

	// bus channel state and read data
	always_comb begin
		aw_have_d = aw_have_q;
		aw_idx_d  = aw_idx_q;
		w_have_d  = w_have_q;
		wdat_d    = wdat_q;
		wstb_d    = wstb_q;
		bvalid_d  = bvalid_q && !s_axi_bready;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q && !s_axi_rready;
		rresp_d   = rresp_q;
		rdata_d   = rdata_q;
		if (s_axi_awvalid && !aw_have_q) begin
			aw_have_d = 1'b1;
			aw_idx_d  = s_axi_awaddr[usps_pkg::ADDR_W-1:2];
		end
		if (s_axi_wvalid && !w_have_q) begin
			w_have_d = 1'b1;
			wdat_d   = s_axi_wdata[7:0];
			wstb_d   = s_axi_wstrb[0];
		end
		if (do_wr) begin
			aw_have_d = 1'b0;
			w_have_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = (aw_idx_q == usps_pkg::IDX_CTRL || aw_idx_q == usps_pkg::IDX_SERIAL_DATA_BUFFER
			          || aw_idx_q == usps_pkg::IDX_BAUD || aw_idx_q == usps_pkg::IDX_ISTAT
			          || aw_idx_q == usps_pkg::IDX_IMASK) ? usps_pkg::RESP_OKAY
			                                              : usps_pkg::RESP_SLVERR;
		end
		if (do_rd) begin
			rvalid_d = 1'b1;
			rresp_d  = usps_pkg::RESP_OKAY;
			unique case (ar_idx)
				usps_pkg::IDX_CTRL:  rdata_d = {24'h0, ctrl_q};
				usps_pkg::IDX_SERIAL_DATA_BUFFER:  rdata_d = {24'h0, serial_data_buffer_q};
				usps_pkg::IDX_BAUD:  rdata_d = {24'h0, baud_q};
				usps_pkg::IDX_ISTAT: rdata_d = {27'h0, ist_q};
				usps_pkg::IDX_IMASK: rdata_d = {27'h0, imsk_q};
				default: begin
					rdata_d = 32'h0;
					rresp_d = usps_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	// software writes first, hardware events after so hardware wins when both hit a field
	always_comb begin
		ctrl_d = ctrl_q;
		baud_d = baud_q;
		serial_data_buffer_d = serial_data_buffer_q;
		imsk_d = imsk_q;
		pend_d = pend_q;
		ist_d  = rd_istat ? '0 : ist_q;  // read of status clears it
		if (do_wr && wstb_q) begin
			unique case (aw_idx_q)
				usps_pkg::IDX_CTRL:  ctrl_d = wdat_q;  // see R1
				usps_pkg::IDX_SERIAL_DATA_BUFFER: begin
					serial_data_buffer_d = wdat_q;
					pend_d = 1'b1;  // see R15
				end
				usps_pkg::IDX_BAUD: begin
					baud_d.overwrite_error_flag       = baud_q.overwrite_error_flag & wdat_q[7];  // see R8
					baud_d.ext_ratio = wdat_q[4:3];  // see R11
					baud_d.bin_div   = wdat_q[2:0];  // see R12; fe and be untouched, see R16
				end
				usps_pkg::IDX_IMASK: imsk_d = wdat_q[usps_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
		if (tx_st_q == TX_IDLE && tx_st_d == TX_RUN) begin
			pend_d = 1'b0;
		end
		if (tx_done_ev) begin
			ctrl_d.tdone = 1'b1;  // see R4, R5
			ist_d[usps_pkg::IRQ_TX] = 1'b1;
		end
		if (frame_ev) begin
			baud_d.fe = fe_val;  // see R9
			baud_d.be = be_val;  // see R10
			ist_d[usps_pkg::IRQ_FE]  = ist_d[usps_pkg::IRQ_FE] | fe_val;
			ist_d[usps_pkg::IRQ_BRK] = ist_d[usps_pkg::IRQ_BRK] | be_val;
		end
		if (load_ev) begin
			serial_data_buffer_d       = rx_byte;
			ctrl_d.rx9   = rx_bit9;  // see R3
			ctrl_d.rdone = 1'b1;  // see R6
			ist_d[usps_pkg::IRQ_RX] = 1'b1;
			if (ctrl_q.rdone) begin
				baud_d.overwrite_error_flag = 1'b1;  // see R8
				ist_d[usps_pkg::IRQ_OWE] = 1'b1;
			end
		end
	end

	// transmitter: frame shifts out LSB first, one bit per bit period
	always_comb begin
		tx_st_d    = tx_st_q;
		tx_sh_d    = tx_sh_q;
		tx_left_d  = tx_left_q;
		tx_cnt_d   = tx_cnt_q;
		tx_done_ev = 1'b0;
		unique case (tx_st_q)
			TX_IDLE: begin
				if (pend_q && rx_st_q != RX_M0) begin
					tx_st_d  = TX_RUN;
					tx_cnt_d = bit_cyc;
					unique case (ctrl_q.mode)  // see R15
						usps_pkg::MODE_SHIFT: begin
							tx_sh_d   = {3'h7, serial_data_buffer_q};
							tx_left_d = 4'h8;
						end
						usps_pkg::MODE_8VAR: begin
							tx_sh_d   = {2'h3, serial_data_buffer_q, 1'b0};
							tx_left_d = 4'ha;
						end
						default: begin
							tx_sh_d   = {1'b1, ctrl_q.tx9, serial_data_buffer_q, 1'b0};  // see R2
							tx_left_d = 4'hb;
						end
					endcase
				end
			end
			TX_RUN: begin
				tx_cnt_d = tx_cnt_q - 16'h0001;
				if (tx_cnt_q == 16'h0001) begin
					tx_cnt_d  = bit_cyc;
					tx_sh_d   = {1'b1, tx_sh_q[10:1]};
					tx_left_d = tx_left_q - 4'h1;
					if (ctrl_q.mode == usps_pkg::MODE_SHIFT) begin
						tx_done_ev = (tx_left_q == 4'h1);  // see R4
					end else begin
						tx_done_ev = (tx_left_q == 4'h2);  // see R4
					end
					if (tx_left_q == 4'h1) begin
						tx_st_d = TX_IDLE;
					end
				end
			end
		endcase
	end

	// receiver: mid-bit sampling for async modes, clocked shift for mode 0
	always_comb begin
		rx_st_d   = rx_st_q;
		rx_sh_d   = rx_sh_q;
		rx_left_d = rx_left_q;
		rx_cnt_d  = rx_cnt_q - 16'h0001;
		brk_cnt_d = rxd_i ? 20'h0 : ((brk_cnt_q == 20'hfffff) ? brk_cnt_q
		                                                       : brk_cnt_q + 20'h1);
		frame_ev  = 1'b0;
		load_ev   = 1'b0;
		fe_val    = !rxd_i;
		be_val    = (brk_cnt_q >= brk_lim);  // see R10
		rx_byte   = (ctrl_q.mode[1]) ? rx_sh_q[7:0] : rx_sh_q[8:1];
		rx_bit9   = (ctrl_q.mode[1]) ? rx_sh_q[8] : rxd_i;  // see R3
		unique case (rx_st_q)
			RX_IDLE: begin
				rx_cnt_d = half_cyc;
				if (ctrl_q.rx_en && ctrl_q.mode == usps_pkg::MODE_SHIFT && !ctrl_q.rdone
				    && tx_st_q == TX_IDLE && !pend_q) begin
					rx_st_d   = RX_M0;
					rx_cnt_d  = bit_cyc;
					rx_left_d = 4'h8;
				end else if (ctrl_q.rx_en && ctrl_q.mode != usps_pkg::MODE_SHIFT
				             && rxd_prev_q && !rxd_i) begin
					rx_st_d = RX_START;
				end
			end
			RX_START: begin
				if (rx_cnt_q == 16'h0001) begin
					rx_cnt_d  = bit_cyc;
					rx_left_d = ctrl_q.mode[1] ? 4'h9 : 4'h8;
					rx_st_d   = rxd_i ? RX_IDLE : RX_DATA;  // false start drops out
				end
			end
			RX_DATA: begin
				if (rx_cnt_q == 16'h0001) begin
					rx_cnt_d  = bit_cyc;
					rx_sh_d   = {rxd_i, rx_sh_q[8:1]};
					rx_left_d = rx_left_q - 4'h1;
					if (rx_left_q == 4'h1) begin
						rx_st_d = RX_STOP;
					end
				end
			end
			RX_STOP: begin
				if (rx_cnt_q == 16'h0001) begin
					rx_st_d  = RX_IDLE;
					frame_ev = 1'b1;
					if (ctrl_q.mode == usps_pkg::MODE_8VAR) begin
						load_ev = !ctrl_q.mp_en || rxd_i;  // see R6, R14
					end else begin
						load_ev = !ctrl_q.mp_en || rx_sh_q[8];  // see R6, R14
					end
				end
			end
			RX_M0: begin
				if (rx_cnt_q == 16'h0001) begin
					rx_cnt_d  = bit_cyc;
					rx_sh_d   = {rxd_i, rx_sh_q[8:1]};  // byte lands in [8:1] as in mode 1
					rx_left_d = rx_left_q - 4'h1;
					if (rx_left_q == 4'h1) begin
						rx_st_d = RX_IDLE;
						load_ev = 1'b1;  // see R6
					end
				end
			end
		endcase
		if (!ctrl_q.rx_en && rx_st_q != RX_IDLE) begin
			rx_st_d  = RX_IDLE;  // see R1
			frame_ev = 1'b0;
			load_ev  = 1'b0;
		end
	end

	// pin drive: mode 0 data on the receive pin, shift clock on the transmit pin
	always_comb begin
		rxd_out_d = tx_sh_q[0];
		rxd_oe_d  = (tx_st_q == TX_RUN) && ctrl_q.mode == usps_pkg::MODE_SHIFT;
		if (ctrl_q.mode == usps_pkg::MODE_SHIFT) begin
			txd_d = !((tx_st_q == TX_RUN && tx_cnt_q > half_cyc)
			       || (rx_st_q == RX_M0 && rx_cnt_q > half_cyc));
		end else begin
			txd_d = (tx_st_q == TX_RUN) ? tx_sh_q[0] : 1'b1;
		end
	end

	assign rxd_o    = rxd_out_q;
	assign rxd_oe_o = rxd_oe_q;
	assign txd_o    = txd_q;
	assign irq_o    = |(ist_q & imsk_q);

	// state registers
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_q     <= usps_pkg::CTRL_RST;
			baud_q     <= usps_pkg::BAUD_RST;
			serial_data_buffer_q     <= usps_pkg::SERIAL_DATA_BUFFER_RST;  // see R7
			ist_q      <= '0;
			imsk_q     <= '0;
			pend_q     <= 1'b0;
			aw_have_q  <= 1'b0;
			aw_idx_q   <= 10'h000;
			w_have_q   <= 1'b0;
			wdat_q     <= 8'h00;
			wstb_q     <= 1'b0;
			bvalid_q   <= 1'b0;
			bresp_q    <= 2'h0;
			rvalid_q   <= 1'b0;
			rresp_q    <= 2'h0;
			rdata_q    <= 32'h0;
			tx_st_q    <= TX_IDLE;
			tx_sh_q    <= 11'h7ff;
			tx_left_q  <= 4'h0;
			tx_cnt_q   <= 16'h0000;
			txd_q      <= 1'b1;
			rxd_out_q  <= 1'b1;
			rxd_oe_q   <= 1'b0;
			rx_st_q    <= RX_IDLE;
			rx_sh_q    <= 9'h000;
			rx_left_q  <= 4'h0;
			rx_cnt_q   <= 16'h0000;
			rxd_prev_q <= 1'b1;
			brk_cnt_q  <= 20'h0;
		end else begin
			ctrl_q     <= ctrl_d;
			baud_q     <= baud_d;
			serial_data_buffer_q     <= serial_data_buffer_d;
			ist_q      <= ist_d;
			imsk_q     <= imsk_d;
			pend_q     <= pend_d;
			aw_have_q  <= aw_have_d;
			aw_idx_q   <= aw_idx_d;
			w_have_q   <= w_have_d;
			wdat_q     <= wdat_d;
			wstb_q     <= wstb_d;
			bvalid_q   <= bvalid_d;
			bresp_q    <= bresp_d;
			rvalid_q   <= rvalid_d;
			rresp_q    <= rresp_d;
			rdata_q    <= rdata_d;
			tx_st_q    <= tx_st_d;
			tx_sh_q    <= tx_sh_d;
			tx_left_q  <= tx_left_d;
			tx_cnt_q   <= tx_cnt_d;
			txd_q      <= txd_d;
			rxd_out_q  <= rxd_out_d;
			rxd_oe_q   <= rxd_oe_d;
			rx_st_q    <= rx_st_d;
			rx_sh_q    <= rx_sh_d;
			rx_left_q  <= rx_left_d;
			rx_cnt_q   <= rx_cnt_d;
			rxd_prev_q <= rxd_i;
			brk_cnt_q  <= brk_cnt_d;
		end
	end
endmodule
`default_nettype wire

// >>> shared/usps_pkg.sv
// usps_pkg: register map, field layouts, reset values and timing counts of the serial port.
// assumes a 100 MHz core clock and a 32-bit AXI4-Lite register bus.
`default_nettype none
package usps_pkg;
	// register indices; byte address is four times the index
	localparam logic [9:0]  IDX_CTRL   = 10'h098;
	localparam logic [9:0]  IDX_SERIAL_DATA_BUFFER   = 10'h099;
	localparam logic [9:0]  IDX_BAUD   = 10'h09e;
	localparam logic [9:0]  IDX_ISTAT  = 10'h0a0;
	localparam logic [9:0]  IDX_IMASK  = 10'h0a1;
	localparam int          ADDR_W     = 12;

	// port modes held in the mode field
	localparam logic [1:0]  MODE_SHIFT = 2'h0;
	localparam logic [1:0]  MODE_8VAR  = 2'h1;
	localparam logic [1:0]  MODE_9FIX  = 2'h2;
	localparam logic [1:0]  MODE_9VAR  = 2'h3;

	// bit periods in core cycles, break limit in half bits
	localparam logic [15:0] MODE0_CYC  = 16'h000c;
	localparam logic [15:0] MODE2_CYC  = 16'h0040;
	localparam logic [15:0] BASE_CYC   = 16'h0010;
	localparam logic [19:0] BRK_HALVES = 20'h00015;

	// interrupt status and mask bit positions and width
	localparam int          IRQ_TX     = 0;
	localparam int          IRQ_RX     = 1;
	localparam int          IRQ_OWE    = 2;
	localparam int          IRQ_FE     = 3;
	localparam int          IRQ_BRK    = 4;
	localparam int          IRQ_W      = 5;

	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// serial_port_control layout, bit 7 first
	typedef struct packed {
		logic [1:0] mode;       // mode_select_high, mode_select_low
		logic       mp_en;      // multiprocessor_enable
		logic       rx_en;
		logic       tx9;        // transmit_ninth_bit
		logic       rx9;        // receive_ninth_bit
		logic       tdone;      // transmit_done_flag
		logic       rdone;      // receive_done_flag
	} usps_ctrl_t;

	// baud_divider_and_errors layout, bit 7 first
	typedef struct packed {
		logic       overwrite_error_flag;        // overwrite_error_flag
		logic       fe;         // frame_error_flag
		logic       be;         // break_error_flag
		logic [1:0] ext_ratio;  // extended_divider_ratio
		logic [2:0] bin_div;
	} usps_baud_t;

	localparam usps_ctrl_t  CTRL_RST   = '{mode: 2'h0, default: 1'b0};
	localparam usps_baud_t  BAUD_RST   = '{ext_ratio: 2'h0, bin_div: 3'h0, default: 1'b0};
	localparam logic [7:0]  SERIAL_DATA_BUFFER_RST   = 8'h00;
endpackage
`default_nettype wire

// >>> sim/usps_uart_assertions.sv
// usps_uart_assertions: bus handshake and line timing checks on the serial port.
// assumes it is bound to usps_uart, one clock domain, active-high reset.
`default_nettype none
module usps_uart_assertions (
	input wire logic        clk_sys_i,
	input wire logic        rst_i,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        txd_o,
	input wire logic        rxd_oe_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	// both halves of a write taken while no answer is pending
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
	endsequence
	sequence s_wr_answered;
		s_axi_bvalid && s_axi_bready;
	endsequence

	// register bus answers and releases
	// the held pair is performed one cycle after it is taken, bvalid follows
	chk_write_answer: assert property (s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer not two cycles after request");
	chk_write_drop: assert property (s_wr_answered |=> !s_axi_bvalid)
		else $error("write answer stayed after handshake");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer not one cycle after request");
	chk_read_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer stayed after handshake");
	chk_read_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while answer pending");
	chk_rdata_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data wider than a byte");

	// line: a low phase lasts at least half of the shortest bit
	chk_txd_low_span: assert property ($fell(txd_o) |-> !txd_o [*6])
		else $error("transmit line low phase too short");
	chk_oe_clock: assert property ($rose(rxd_oe_o) |-> ##[0:12] !txd_o)
		else $error("no shift clock after shift output enabled");
endmodule
`default_nettype wire

// >>> sim/usps_line_model.sv
// usps_line_model: remote asynchronous serial partner, sender and receiver.
// assumes the core clock and bit periods counted in core cycles.
`default_nettype none
module usps_line_model (
	input  wire logic clk_sys_i,
	input  wire logic txd_i,
	output var logic  line_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle line rests at the marking level
	initial line_o = 1'b1;

	// start bit, then n bits LSB first (last is the stop), then back to idle
	task automatic send(input logic [9:0] bits, input int n, input int per);
		line_o <= 1'b0;
		repeat (per) @(posedge clk_sys_i);
		for (int i = 0; i < n; i++) begin
			line_o <= bits[i];
			repeat (per) @(posedge clk_sys_i);
		end
		line_o <= 1'b1;
	endtask

	// samples start and n further bits at mid-bit, LSB first
	task automatic recv(input int n, input int per, output logic [10:0] got);
		got = '0;
		@(negedge txd_i);
		repeat (per / 2) @(posedge clk_sys_i);
		for (int i = 0; i <= n; i++) begin
			got[i] = txd_i;
			repeat (per) @(posedge clk_sys_i);
		end
	endtask
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// tb_top: register-level tests of the serial port against a line partner.
// assumes usps_pkg, usps_uart, the checker and the line model compiled first.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        awv = 1'b0;
	logic        wv = 1'b0;
	logic        arv = 1'b0;
	logic [11:0] awa = '0;
	logic [11:0] ara = '0;
	logic [31:0] wd = '0;
	logic        awr, wrr, bv, arr, rv, rxd_o, oe, txd, irq, line;
	logic [31:0] rd_d;
	logic [1:0]  br, rr;
	logic [10:0] g;
	int          mismatches = 0;
	int          total_checks = 0;

	always #5 clk_sys_i = ~clk_sys_i;

	usps_uart i_usps_uart (
		.clk_sys_i     (clk_sys_i),
		.rst_i         (rst_i),
		.s_axi_awaddr  (awa),
		.s_axi_awvalid (awv),
		.s_axi_awready (awr),
		.s_axi_wdata   (wd),
		.s_axi_wstrb   (4'h1),
		.s_axi_wvalid  (wv),
		.s_axi_wready  (wrr),
		.s_axi_bresp   (br),
		.s_axi_bvalid  (bv),
		.s_axi_bready  (1'b1),
		.s_axi_araddr  (ara),
		.s_axi_arvalid (arv),
		.s_axi_arready (arr),
		.s_axi_rdata   (rd_d),
		.s_axi_rresp   (rr),
		.s_axi_rvalid  (rv),
		.s_axi_rready  (1'b1),
		.rxd_i         (line),
		.rxd_o         (rxd_o),
		.rxd_oe_o      (oe),
		.txd_o         (txd),
		.irq_o         (irq)
	);
	usps_line_model m (.clk_sys_i(clk_sys_i), .txd_i(txd), .line_o(line));

	task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// one write: address and data offered together, each dropped when taken
	task automatic wr(input logic [9:0] idx, input logic [7:0] d,
			input logic [1:0] er = usps_pkg::RESP_OKAY);
		int n;
		n = 0;
		awa <= {idx, 2'h0};
		wd <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			n++;
			if (awr) awv <= 1'b0;
			if (wrr) wv <= 1'b0;
		end while (!bv && n < 500);
		cmp("bvalid", 32'h1, {31'h0, bv});
		cmp($sformatf("bresp %h", idx), {30'h0, er}, {30'h0, br});
	endtask

	// one read, compared with the expected byte and response
	task automatic rdc(input logic [9:0] idx, input logic [7:0] exp,
			input logic [1:0] er = usps_pkg::RESP_OKAY);
		int n;
		n = 0;
		ara <= {idx, 2'h0};
		arv <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			n++;
			if (arr) arv <= 1'b0;
		end while (!rv && n < 500);
		cmp("rvalid", 32'h1, {31'h0, rv});
		cmp($sformatf("reg %h", idx), {24'h0, exp}, rd_d);
		cmp($sformatf("rresp %h", idx), {30'h0, er}, {30'h0, rr});
	endtask

	// sends one character and checks the frame seen on the line
	task automatic txc(input logic [7:0] c, b, d, input int per, n, input logic [10:0] e);
		wr(usps_pkg::IDX_BAUD, b);
		wr(usps_pkg::IDX_CTRL, c);
		fork
			m.recv(n, per, g);
			wr(usps_pkg::IDX_SERIAL_DATA_BUFFER, d);
		join
		cmp("frame", {21'h0, e}, {21'h0, g});
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// watchdog against a hung handshake or line
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		mismatches++;
		wrap_up();
	end

	// main sequence
	initial begin
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rdc(usps_pkg::IDX_CTRL, 8'h00);
		rdc(usps_pkg::IDX_SERIAL_DATA_BUFFER, 8'h00);
		rdc(usps_pkg::IDX_BAUD, 8'h00);
		rdc(10'h050, 8'h00, usps_pkg::RESP_SLVERR);
		wr(10'h050, 8'h5a, usps_pkg::RESP_SLVERR);
		wr(usps_pkg::IDX_BAUD, 8'hff);
		rdc(usps_pkg::IDX_BAUD, 8'h1f);
		wr(usps_pkg::IDX_IMASK, 8'h01);
		txc(8'h40, 8'h00, 8'ha5, 16, 9, {2'b01, 8'ha5, 1'b0});
		cmp("irq", 32'h1, {31'h0, irq});
		rdc(usps_pkg::IDX_CTRL, 8'h42);
		rdc(usps_pkg::IDX_CTRL, 8'h42);
		rdc(usps_pkg::IDX_ISTAT, 8'h01);
		cmp("irq", 32'h0, {31'h0, irq});
		txc(8'hc8, 8'h00, 8'h3c, 16, 10, {2'b11, 8'h3c, 1'b0});
		txc(8'h80, 8'h00, 8'hc3, 64, 10, {2'b10, 8'hc3, 1'b0});
		txc(8'h40, 8'h09, 8'h6e, 64, 9, {2'b01, 8'h6e, 1'b0});
		txc(8'h40, 8'h12, 8'h6e, 192, 9, {2'b01, 8'h6e, 1'b0});
		// shift-register mode: data on rxd_o taken at each rising shift clock
		wr(usps_pkg::IDX_CTRL, 8'h00);
		fork
			for (int i = 0; i < 8; i++) begin
				@(posedge txd);
				g[i] = rxd_o;
			end
			wr(usps_pkg::IDX_SERIAL_DATA_BUFFER, 8'h96);
		join
		cmp("shift", 32'h96, {24'h0, g[7:0]});
		repeat (8) @(posedge clk_sys_i);
		rdc(usps_pkg::IDX_CTRL, 8'h02);
		// reception, overwrite, frame and break errors
		wr(usps_pkg::IDX_BAUD, 8'h00);
		wr(usps_pkg::IDX_CTRL, 8'h50);
		m.send({1'b1, 8'h5a}, 9, 16);
		rdc(usps_pkg::IDX_CTRL, 8'h55);
		rdc(usps_pkg::IDX_SERIAL_DATA_BUFFER, 8'h5a);
		m.send({1'b1, 8'h11}, 9, 16);
		rdc(usps_pkg::IDX_BAUD, 8'h80);
		wr(usps_pkg::IDX_BAUD, 8'h00);
		rdc(usps_pkg::IDX_BAUD, 8'h00);
		wr(usps_pkg::IDX_CTRL, 8'h50);
		m.send({1'b0, 8'h33}, 9, 16);
		rdc(usps_pkg::IDX_BAUD, 8'h40);
		rdc(usps_pkg::IDX_CTRL, 8'h51);
		wr(usps_pkg::IDX_CTRL, 8'h70);
		m.send({1'b0, 8'h77}, 9, 16);
		rdc(usps_pkg::IDX_CTRL, 8'h70);
		wr(usps_pkg::IDX_CTRL, 8'h40);
		m.send({1'b1, 8'h99}, 9, 16);
		rdc(usps_pkg::IDX_CTRL, 8'h40);
		wr(usps_pkg::IDX_BAUD, 8'h00);
		rdc(usps_pkg::IDX_BAUD, 8'h40);
		wr(usps_pkg::IDX_CTRL, 8'hd0);
		m.send(10'h000, 10, 16);
		rdc(usps_pkg::IDX_BAUD, 8'h60);
		wr(usps_pkg::IDX_CTRL, 8'hd0);
		m.send(10'h300, 10, 16);
		rdc(usps_pkg::IDX_BAUD, 8'h00);
		rdc(usps_pkg::IDX_CTRL, 8'hd5);
		// shift-register reception with the line resting high
		wr(usps_pkg::IDX_CTRL, 8'h10);
		repeat (110) @(posedge clk_sys_i);
		rdc(usps_pkg::IDX_SERIAL_DATA_BUFFER, 8'hff);
		wrap_up();
	end
endmodule

bind usps_uart usps_uart_assertions i_usps_uart_assertions (
	.clk_sys_i, .rst_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .txd_o, .rxd_oe_o
);
`default_nettype wire
